// File: tb_top.sv
// Purpose: Self-checking bench for the location window and config decoder
// Assumes: The bench plays the VMEbus master and drives at falling edges
// Notes:   Fixed observation windows let absent responses be seen
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import vsmc_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [31:0] va = 32'h0, offs = 32'h0, wdat = 32'h0, rdat, caddr, got_addr;
    logic [5:0]  am = 6'h0;
    logic        as_n = 1'b1, ds_n = 1'b1, wr_n = 1'b1, own = 1'b0, hit = 1'b0, lss = 1'b0;
    logic        rwr = 1'b0, ridx = 1'b0, dtk, dtk_seen, creq, cack, ctype, cwr;
    logic        cfg_seen, got_type, got_wr;
    logic [7:0]  bnum = 8'h05;
    logic [3:0]  dly = 4'h0, irq, irq_seen;
    int          fails = 0, check_count = 0, irq_cnt;

    always #2 ref_clk = ~ref_clk;

    vsmc_decode vsmc_decode_i (.ref_clk(ref_clk), .rstn(rstn), .vme_address_lines(va),
        .vme_am(am), .vme_as_n(as_n), .vme_ds_n(ds_n), .vme_write_n(wr_n),
        .vme_dtack_oe(dtk), .own_master_busy(own), .image_hit(hit), .local_space_select(lss),
        .slave_image_translation_offset(offs), .bus_number(bnum), .reg_wr(rwr),
        .reg_idx(ridx), .reg_wdata(wdat), .reg_rdata(rdat), .lm_irq(irq), .cfg_req(creq),
        .cfg_ack(cack), .cfg_addr(caddr), .cfg_type1(ctype), .cfg_write(cwr));

    vsmc_cfg_target vsmc_cfg_target_i (.ref_clk(ref_clk), .rstn(rstn), .cfg_req(creq),
        .ack_delay(dly), .cfg_ack(cack));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic reg_write(input logic i, input logic [31:0] d);
        @(negedge ref_clk);
        rwr = 1'b1;
        ridx = i;
        wdat = d;
        @(negedge ref_clk);
        rwr = 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic i, input logic [31:0] e);
        @(negedge ref_clk);
        ridx = i;
        repeat (2) @(negedge ref_clk);
        chk_word("reg_rdata", e, rdat);
    endtask : reg_check

    task automatic vme_cyc(input logic [31:0] a, input logic [5:0] m, input logic o);
        @(negedge ref_clk);
        va = a;
        am = m;
        own = o;
        as_n = 1'b0;
        ds_n = 1'b0;
        {irq_seen, dtk_seen, cfg_seen, irq_cnt} = '0;
        repeat (30) begin
            @(negedge ref_clk);
            irq_seen |= irq;
            dtk_seen |= dtk;
            irq_cnt += (irq != 4'h0);
            if (creq && !cfg_seen) begin
                cfg_seen = 1'b1;
                {got_addr, got_type, got_wr} = {caddr, ctype, cwr};
            end
        end
        as_n = 1'b1;
        ds_n = 1'b1;
        va = ~a;
        for (int i = 0; i < 10 && dtk !== 1'b0; i++) @(negedge ref_clk);
        chk_word("dtack_release", 32'h0, {31'h0, dtk});
        own = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask : vme_cyc

    task automatic t_regs;
        chk_word("irq_reset", 32'h0, {27'h0, creq, irq});
        reg_check(REG_IDX_CTL, CTL_RESET);
        reg_check(REG_IDX_BASE, BASE_RESET);
        reg_write(REG_IDX_CTL, 32'hffff_ffff);
        reg_check(REG_IDX_CTL, 32'h80ff_0000);
        reg_write(REG_IDX_BASE, 32'hffff_ffff);
        reg_check(REG_IDX_BASE, 32'hffff_f000);
        reg_write(REG_IDX_BASE, 32'h1234_5000);
        reg_write(REG_IDX_CTL, 32'h80f2_0000);
    endtask : t_regs

    task automatic t_monitors;
        for (int i = 0; i < 4; i++) begin
            wr_n = i[0];
            vme_cyc(32'h1234_5040 | (i << 3), 6'h09, 1'b1);
            chk_word("lm_irq", 32'h1 << i, {28'h0, irq_seen});
            chk_word("irq_pulses", 32'h1, irq_cnt);
            chk_word("dtack_own", 32'h1, {31'h0, dtk_seen});
        end
        reg_check(REG_IDX_CTL, 32'h80f2_0007);
        vme_cyc(32'h1234_5fe8, 6'h09, 1'b0);
        chk_word("lm_irq_other", 32'h2, {28'h0, irq_seen});
        chk_word("dtack_other", 32'h0, {31'h0, dtk_seen});
    endtask : t_monitors

    task automatic t_decode;
        logic [31:0] tc [8] = '{32'h80f2_0000, 32'h80d2_0000, 32'h80d2_0000, 32'h8072_0000,
            32'h00f2_0000, 32'h80f1_0000, 32'h80f0_0000, 32'h80f2_0000};
        logic [5:0]  tm [8] = '{6'h0b, 6'h0d, 6'h09, 6'h0a, 6'h09, 6'h39, 6'h29, 6'h09};
        logic [31:0] ta [8] = '{32'h1234_5000, 32'h1234_5000, 32'h1234_5000, 32'h1234_5000,
            32'h1234_5000, 32'hee34_5010, 32'h9999_5018, 32'h1234_6000};
        logic [3:0]  te [8] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h4, 4'h8, 4'h0};
        for (int i = 0; i < 8; i++) begin
            reg_write(REG_IDX_CTL, tc[i]);
            vme_cyc(ta[i], tm[i], 1'b1);
            chk_word("lm_irq_decode", {28'h0, te[i]}, {28'h0, irq_seen});
            chk_word("dtack_decode", {31'h0, |te[i]}, {31'h0, dtk_seen});
        end
    endtask : t_decode

    task automatic t_cfg;
        logic [31:0] ca [2] = '{32'hff05_210c, 32'h7711_4a5c};
        logic [31:0] co [2] = '{32'h0000_0800, 32'h0000_0100};
        logic [31:0] s;
        logic        t1;
        reg_write(REG_IDX_CTL, 32'h0000_0000);
        hit = 1'b1;
        vme_cyc(ca[0], 6'h09, 1'b0);
        chk_word("cfg_no_space", 32'h0, {31'h0, cfg_seen});
        lss = 1'b1;
        for (int i = 0; i < 2; i++) begin
            {offs, dly, wr_n} = {co[i], 4'(i * 6), i[0] == 1'b0};
            s = ca[i] + co[i];
            t1 = ca[i][23:16] != bnum;
            // Device select kept within 0..20, non-block A32 user AM only
            vme_cyc(ca[i], 6'h09, 1'b0);
            chk_word("cfg_addr", t1 ? {s[31:2], 2'b01} : ((32'h1 << (11 + s[15:11]))
                | {21'h0, s[10:2], 2'b00}), got_addr);
            chk_word("cfg_type", {31'h0, t1}, {31'h0, got_type});
            chk_word("cfg_seen_wr_dtk", {30'h1, i[0], 1'b1},
                {29'h0, cfg_seen, got_wr, dtk_seen});
        end
    endtask : t_cfg

    initial begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        t_regs;
        t_monitors;
        t_decode;
        t_cfg;
        print_verdict;
    end
endmodule : tb_top

`default_nettype wire

// File: vsmc_cfg_target.sv
// Purpose: PCI configuration target model that answers config requests
// Assumes: The request is a level held until acknowledged
// Notes:   The delay input lets the bench choose a prompt or a slow answer
`timescale 1ns/10ps
`default_nettype none

module vsmc_cfg_target (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       cfg_req,
    input  wire logic [3:0] ack_delay,
    output logic            cfg_ack
);
    logic [3:0] wait_q;

    // One pulse per request, and only while the request stands
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wait_q  <= 4'h0;
            cfg_ack <= 1'b0;
        end else if (cfg_req && !cfg_ack) begin
            wait_q  <= wait_q + 4'h1;
            cfg_ack <= (wait_q >= ack_delay);
        end else begin
            wait_q  <= 4'h0;
            cfg_ack <= 1'b0;
        end
    end
endmodule : vsmc_cfg_target

`default_nettype wire

// File: vsmc_decode.sv
// Purpose: Decode VMEbus slave cycles for the location window and config-space images
// Assumes: VMEbus pins arrive asynchronously; image match and offsets come from local logic
// Notes:   Location window data is never stored or driven; config cycles go out as requests
`timescale 1ns/10ps
`default_nettype none

module vsmc_decode
    import vsmc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // VMEbus slave pins
    input  wire logic [31:0] vme_address_lines,
    input  wire logic [5:0]  vme_am,
    input  wire logic        vme_as_n,
    input  wire logic        vme_ds_n,
    input  wire logic        vme_write_n,
    output logic             vme_dtack_oe,
    // Local state
    input  wire logic        own_master_busy,
    input  wire logic        image_hit,
    input  wire logic        local_space_select,
    input  wire logic [31:0] slave_image_translation_offset,
    input  wire logic [7:0]  bus_number,
    // Register port
    input  wire logic        reg_wr,
    input  wire logic        reg_idx,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    // Interrupt and config request outputs, and the config acknowledge input
    output logic [3:0]       lm_irq,
    output logic             cfg_req,
    input  wire logic        cfg_ack,
    output logic [31:0]      cfg_addr,
    output logic             cfg_type1,
    output logic             cfg_write
);

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [31:0]       addr_s;
    logic [5:0]        am_s;
    logic              as_n_s;
    logic              ds_n_s;
    logic              write_n_s;
    vsmc_state_t       state_q;
    logic [31:0]       ctl_q;
    logic [31:0]       base_q;
    logic [2:0]        last_q;
    logic [19:0]       cmp_mask;
    logic              space_ok;
    logic              am_ok;
    logic              am_block;
    logic              base_ok;
    logic              lm_hit;
    logic              cfg_hit;
    logic [31:0]       cfg_sum;
    logic [20:0]       dev_onehot;
    logic [31:0]       type0_addr;
    logic [31:0]       cfg_addr_d;

    // Every pin passes two flops; only the second stage is read
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= {vme_address_lines, vme_am, vme_as_n, vme_ds_n, vme_write_n};
            sync2_q <= sync1_q;
        end
    end

    assign addr_s    = sync2_q[40:9];
    assign am_s      = sync2_q[8:3];
    assign as_n_s    = sync2_q[2];
    assign ds_n_s    = sync2_q[1];
    assign write_n_s = sync2_q[0];

    // Single shared copy serves all four monitors
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_q  <= CTL_RESET;
            base_q <= BASE_RESET;
        end else if (reg_wr) begin
            if (reg_idx == REG_IDX_CTL) begin
                ctl_q  <= reg_wdata & CTL_WR_MASK;
            end else begin
                base_q <= reg_wdata & BASE_WR_MASK;
            end
        end
    end

    // Control readback also shows the last monitor fired
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_idx == REG_IDX_CTL) begin
            reg_rdata <= ctl_q | {29'h0000_0000, last_q};
        end else begin
            reg_rdata <= base_q;
        end
    end

    // Space and AM qualification for the location window
    always_comb begin
        cmp_mask = MASK_A32;
        space_ok = 1'b0;
        case (ctl_q[CTL_VAS_LSB +: 4])
            VAS_A16: begin
                cmp_mask = MASK_A16;
                space_ok = (am_s[5:3] == AM_GRP_A16);
            end
            VAS_A24: begin
                cmp_mask = MASK_A24;
                space_ok = (am_s[5:3] == AM_GRP_A24);
            end
            VAS_A32: begin
                cmp_mask = MASK_A32;
                space_ok = (am_s[5:3] == AM_GRP_A32);
            end
            default: begin
                cmp_mask = MASK_A32;
                space_ok = 1'b0;
            end
        endcase
    end

    // A16 has no block modes, so no AM kind is refused as block there
    assign am_block = (am_s[1:0] != AM_KIND_DATA) && (am_s[1:0] != AM_KIND_PGM)
                      && (am_s[5:3] != AM_GRP_A16);
    assign am_ok    = ((am_s[1:0] == AM_KIND_PGM) ? ctl_q[CTL_PGM_LSB + 1]
                                                  : ctl_q[CTL_PGM_LSB])
                      && (am_s[2] ? ctl_q[CTL_SUP_LSB + 1] : ctl_q[CTL_SUP_LSB]);
    assign base_ok  = ((addr_s[31:BASE_LSB] ^ base_q[31:BASE_LSB]) & cmp_mask) == 20'h00000;
    assign lm_hit   = ctl_q[CTL_EN_BIT] && space_ok && am_ok && !am_block && base_ok;

    // Config path; space and cycle-type legality is left to software and masters
    assign cfg_hit  = image_hit && local_space_select;
    assign cfg_sum  = addr_s + slave_image_translation_offset;

    genvar gi;
    generate
        for (gi = 0; gi <= DEV_SEL_MAX; gi++) begin : g_devsel
            assign dev_onehot[gi] = (cfg_sum[15:11] == 5'(gi));
        end
    endgenerate

    assign type0_addr = {dev_onehot, cfg_sum[10:2], CFG_TYPE0};
    assign cfg_addr_d = (addr_s[23:16] == bus_number) ? type0_addr
                      : {cfg_sum[31:2], CFG_TYPE1};

    // Cycle sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (!as_n_s && !ds_n_s) begin
                        state_q <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    state_q <= (cfg_hit && !lm_hit) ? ST_CFG : ST_HOLD;
                end
                ST_CFG: begin
                    if (cfg_ack) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (as_n_s) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // One interrupt pulse per window access; data is never latched
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mon
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    lm_irq[gi] <= 1'b0;
                end else begin
                    lm_irq[gi] <= (state_q == ST_DECODE) && lm_hit
                                  && (addr_s[4:3] == 2'(gi));
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            last_q <= 3'h0;
        end else if ((state_q == ST_DECODE) && lm_hit) begin
            last_q <= {1'b1, addr_s[4:3]};
        end
    end

    // Acknowledge our own window cycle and every completed config cycle, so a lone bridge cannot hang
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vme_dtack_oe <= 1'b0;
        end else if (state_q == ST_DECODE) begin
            vme_dtack_oe <= lm_hit && own_master_busy;
        end else if ((state_q == ST_CFG) && cfg_ack) begin
            vme_dtack_oe <= 1'b1;
        end else if ((state_q == ST_HOLD) && as_n_s) begin
            vme_dtack_oe <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_req   <= 1'b0;
            cfg_addr  <= 32'h0000_0000;
            cfg_type1 <= 1'b0;
            cfg_write <= 1'b0;
        end else if ((state_q == ST_DECODE) && cfg_hit && !lm_hit) begin
            cfg_req   <= 1'b1;
            cfg_addr  <= cfg_addr_d;
            cfg_type1 <= (addr_s[23:16] != bus_number);
            cfg_write <= !write_n_s;
        end else if (cfg_ack) begin
            cfg_req   <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Checks sit on registered outputs, so those triggered by a decode look one edge after it
    chk_irq_index: assert property ((state_q == ST_DECODE) && lm_hit
        |=> lm_irq == (4'h1 << $past(addr_s[4:3])))
        else $error("Wrong monitor interrupt for address bits 4:3");

    chk_irq_only_decode: assert property ((state_q != ST_DECODE) |=> (lm_irq == 4'h0))
        else $error("Monitor interrupt outside a decode");

    chk_space_refused: assert property ((state_q == ST_DECODE) && !space_ok
        |=> (lm_irq == 4'h0))
        else $error("Monitor fired for the wrong address space");

    chk_base_miss: assert property ((state_q == ST_DECODE) && !base_ok
        |=> (lm_irq == 4'h0))
        else $error("Monitor fired outside the window base");

    chk_window_first: assert property ((state_q == ST_DECODE) && lm_hit
        |=> !cfg_req && (lm_irq != 4'h0))
        else $error("Config cycle issued for a window access");

    chk_one_decode: assert property ((state_q == ST_HOLD) && !as_n_s
        |=> (state_q == ST_HOLD))
        else $error("Second decode within one address strobe");

    chk_irq_enable: assert property ((lm_irq != 4'h0) |-> $past(ctl_q[CTL_EN_BIT]))
        else $error("Monitor interrupt while window disabled");

    chk_irq_pulse: assert property ((lm_irq != 4'h0) |=> (lm_irq == 4'h0))
        else $error("Monitor interrupt longer than one cycle");

    chk_own_dtack: assert property ((state_q == ST_DECODE) && lm_hit && own_master_busy
        |=> vme_dtack_oe)
        else $error("No DTACK for own window access");

    chk_other_dtack: assert property ((state_q == ST_DECODE) && !own_master_busy
        && !(cfg_hit && !lm_hit) |=> !vme_dtack_oe)
        else $error("DTACK driven for another master");

    chk_dtack_release: assert property ((state_q == ST_HOLD) && as_n_s |=> !vme_dtack_oe)
        else $error("DTACK held after address strobe release");

    chk_block_refused: assert property ((state_q == ST_DECODE) && am_block
        |=> (lm_irq == 4'h0))
        else $error("Block cycle fired a monitor");

    chk_cfg_type: assert property ((state_q == ST_DECODE) && cfg_hit && !lm_hit
        |=> cfg_req && (cfg_type1 == ($past(addr_s[23:16]) != $past(bus_number))))
        else $error("Wrong configuration cycle type");

    chk_cfg_write: assert property ((state_q == ST_DECODE) && cfg_hit && !lm_hit
        |=> cfg_write == !$past(write_n_s))
        else $error("Config direction does not follow the cycle");

    chk_cfg_dtack: assert property ((state_q == ST_CFG) && cfg_ack |=> vme_dtack_oe)
        else $error("No DTACK after config cycle completed");

    chk_type0_lines: assert property (cfg_req && !cfg_type1
        |-> ($countones(cfg_addr[31:11]) <= 1) && (cfg_addr[1:0] == CFG_TYPE0))
        else $error("Type 0 device select not one-hot");

    chk_type0_select: assert property ((state_q == ST_DECODE) && cfg_hit && !lm_hit
        && (addr_s[23:16] == bus_number) && (cfg_sum[15:11] <= 5'(DEV_SEL_MAX))
        |=> $onehot(cfg_addr[31:11]) && cfg_addr[11 + $past(cfg_sum[15:11])])
        else $error("Type 0 device select line wrong");

    chk_type0_func: assert property ((state_q == ST_DECODE) && cfg_hit && !lm_hit
        && (addr_s[23:16] == bus_number)
        |=> cfg_addr[10:0] == {$past(cfg_sum[10:2]), CFG_TYPE0})
        else $error("Type 0 register or function bits wrong");

    chk_type1_addr: assert property ((state_q == ST_DECODE) && cfg_hit && !lm_hit
        && (addr_s[23:16] != bus_number)
        |=> cfg_addr == {$past(cfg_sum[31:2]), CFG_TYPE1})
        else $error("Type 1 address not the translated sum");

    chk_cfg_stands: assert property (cfg_req && !cfg_ack |=> cfg_req ##0 $stable(cfg_addr))
        else $error("Config request dropped before acknowledge");

    cov_own_window: cover property ((state_q == ST_DECODE) && lm_hit && own_master_busy
        ##1 vme_dtack_oe);
    cov_other_window: cover property ((state_q == ST_DECODE) && lm_hit && !own_master_busy);
    cov_type0: cover property (cfg_req && !cfg_type1 && cfg_ack);
    cov_type1: cover property (cfg_req && cfg_type1 && cfg_ack);
    cov_block_refused: cover property ((state_q == ST_DECODE) && am_block);

endmodule : vsmc_decode

`default_nettype wire

// File: vsmc_pkg.sv
// Purpose: Constants for the VMEbus slave location-window and config-cycle decoder
// Assumes: One 250 MHz clock, active-low asynchronous reset
// Notes:   Register indices, field positions and reset values are gathered here
package vsmc_pkg;

    // Local register port indices
    localparam logic       REG_IDX_CTL  = 1'b0;
    localparam logic       REG_IDX_BASE = 1'b1;

    // location_window_control fields
    localparam int         CTL_EN_BIT   = 31;
    localparam int         CTL_PGM_LSB  = 22;
    localparam int         CTL_SUP_LSB  = 20;
    localparam int         CTL_VAS_LSB  = 16;
    localparam int         CTL_LAST_LSB = 0;
    localparam logic [31:0] CTL_WR_MASK = 32'h80ff_0000;
    localparam logic [31:0] CTL_RESET   = 32'h0000_0000;

    // location_window_base field, window_base_field occupies [31:12]
    localparam int         BASE_LSB     = 12;
    localparam logic [31:0] BASE_WR_MASK = 32'hffff_f000;
    localparam logic [31:0] BASE_RESET   = 32'h0000_0000;

    // vme_space_select encodings
    localparam logic [3:0] VAS_A16      = 4'h0;
    localparam logic [3:0] VAS_A24      = 4'h1;
    localparam logic [3:0] VAS_A32      = 4'h2;

    // Address modifier space groups (bits 5:3) and cycle kinds (bits 1:0)
    localparam logic [2:0] AM_GRP_A32   = 3'h1;
    localparam logic [2:0] AM_GRP_A16   = 3'h5;
    localparam logic [2:0] AM_GRP_A24   = 3'h7;
    localparam logic [1:0] AM_KIND_DATA = 2'h1;
    localparam logic [1:0] AM_KIND_PGM  = 2'h2;

    // Compare masks over window_base_field for each space
    localparam logic [19:0] MASK_A32    = 20'hfffff;
    localparam logic [19:0] MASK_A24    = 20'h00fff;
    localparam logic [19:0] MASK_A16    = 20'h0000f;

    // Highest device select with a defined one-hot line
    localparam int         DEV_SEL_MAX  = 20;
    localparam logic [1:0] CFG_TYPE0    = 2'h0;
    localparam logic [1:0] CFG_TYPE1    = 2'h1;

    localparam int         SYNC_W       = 41;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DECODE = 2'b01,
        ST_CFG    = 2'b10,
        ST_HOLD   = 2'b11
    } vsmc_state_t;

endpackage : vsmc_pkg
